// file: inc/shp_pkg.sv
// shared constants and carrier types for the slave host port block.
// assumes a single 100 MHz clock; every host pin is already synchronous.
//
// How it works
// R1: the status-move instruction copies accumulator bits 7..4 into status bits 7..4 and keeps bits 3..0.
// R2: host read and write strobes act on edges, and the flags change only after the trailing edge.
// R3: while the host reads the status byte, firmware updates to it are held back until the read ends.
// R4: after reset, port 2 bits 7..4 are plain port latch outputs with no flag or transfer function; the code drives bits 6..4 only, bit 7 is an input.
// R5: the flag-enable instruction turns port 2 bit 4 into the output-full pin.
// R6: with flags enabled, a one in port 2 bit 4 shows the output-full flag and a zero holds the pin low.
// R7: with flags enabled, a one in port 2 bit 5 shows the inverse input-full flag and a zero holds it low.
// R8: the transfer-enable instruction turns port 2 bit 6 into the transfer request, set by writing a one.
// R9: the request drops on acknowledge with a read or write strobe, or when transfer-enable runs again.
// R10: with transfers enabled, a low acknowledge on port 2 bit 7 selects the data buffers.
// R11: select low means data and clears the command flag on a host write; select high sets it.
// R12: a host read returns the output buffer for data or the status byte for commands.
// R13: a host write loads the bus byte into the input buffer for data and commands alike.
// R14: firmware loading the output buffer sets output-full and a host data read clears it;
//      a host write sets input-full and a firmware read of the input buffer clears it.
// R15: status bits 3..0 are output-full, input-full, firmware flag and command flag, from bit 0.
package shp_pkg;
	// instruction opcodes
	localparam logic [7:0] SHP_OPC_STATUS_MOVE = 8'h90;
	localparam logic [7:0] SHP_OPC_EN_FLAGS = 8'hF5;
	localparam logic [7:0] SHP_OPC_EN_DMA = 8'hE5;
	// status bit positions
	localparam int SHP_ST_OBF = 0;
	localparam int SHP_ST_IBF = 1;
	localparam int SHP_ST_F0 = 2;
	localparam int SHP_ST_F1 = 3;
	localparam int SHP_ST_USER_LO = 4;
	localparam int SHP_ST_USER_HI = 7;
	// port 2 upper nibble positions, index 0 is port2_bit4
	localparam int SHP_P2_OBF = 0;
	localparam int SHP_P2_IBF = 1;
	localparam int SHP_P2_DRQ = 2;
	localparam int SHP_P2_TRANSFER_ACKNOWLEDGE_PIN = 3;
	// reset values
	localparam logic [7:0] SHP_STATUS_RST = 8'h00;
	localparam logic [7:0] SHP_BYTE_RST = 8'h00;
	localparam logic [3:0] SHP_P2_RST = 4'hF;
	localparam logic [3:0] SHP_USER_RST = 4'h0;

	// what a strobe remembers from its leading edge
	typedef struct packed {
		logic sel;
		logic cmd;
	} shp_attr_t;

	// host bus pins, all active low except select and data
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic command_data_select;
		logic [7:0] data;
	} shp_host_in_t;

	// firmware side requests, each *_stb is a one-cycle pulse
	typedef struct packed {
		logic exec_stb;
		logic [7:0] opcode;
		logic [7:0] acc;
		logic obuf_wr_stb;
		logic [7:0] obuf_data;
		logic ibuf_rd_stb;
		logic f0_wr_stb;
		logic f0_val;
		logic p2_wr_stb;
		logic [3:0] p2_hi;
	} shp_fw_in_t;
endpackage : shp_pkg

// file: rtl/shp_strobe.sv
// edge tracker for one active-low host strobe.
// assumes the strobe is synchronous to clk and the qualifier is valid
// when the strobe falls.
`timescale 1ns/1ns
module shp_strobe (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic strobe_n,
	input wire shp_pkg::shp_attr_t attr,
	output logic lead,
	output logic trail,
	output logic active,
	output shp_pkg::shp_attr_t attr_q
);
	import shp_pkg::*;

	typedef struct packed {
		logic prev;
		logic act;
		shp_attr_t attr;
	} shp_strb_st_t;

	shp_strb_st_t st_ff;
	shp_strb_st_t nxt_st;

	// an unselected falling edge is ignored, so its rise is ignored too
	assign lead = st_ff.prev & ~strobe_n & attr.sel; // [R2]
	assign trail = ~st_ff.prev & strobe_n & st_ff.act; // [R2]
	assign active = st_ff.act;
	assign attr_q = st_ff.attr;

	// next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.prev = strobe_n;
		if (lead) begin
			nxt_st.act = 1'b1;
			nxt_st.attr = attr;
		end else if (trail) begin
			nxt_st.act = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{prev: 1'b1, act: 1'b0, attr: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	AST_TRAIL_NEEDS_LEAD: assert property (@(posedge clk) disable iff (!rst_n)
		trail |-> ($past(lead) || $past(active))) // [R2]
		else $error("trailing edge without a taken leading edge");
endmodule : shp_strobe

// file: rtl/shp_host_port.sv
// slave host port: status byte, data buffers, flag pins and transfer
// handshake. assumes firmware requests arrive as one-cycle pulses and
// the host never asserts read and write strobes together.
`timescale 1ns/1ns
module shp_host_port (
	input wire logic clk,
	input wire logic rstn,
	input wire shp_pkg::shp_host_in_t host_in,
	input wire shp_pkg::shp_fw_in_t fw_in,
	input wire logic port2_bit7,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	output logic [2:0] port2_pins,
	output logic [7:0] fw_status,
	output logic [7:0] fw_ibuf_data
);
	import shp_pkg::*;

	typedef struct packed {
		logic output_full_flag;
		logic input_full_flag;
		logic f0;
		logic command_data_flag;
		logic [3:0] user_status_bits;
		logic [7:0] obuf;
		logic [7:0] ibuf;
		logic [7:0] wr_data;
		logic flags_en;
		logic dma_en;
		logic transfer_request_pin;
		logic [3:0] p2_latch;
		logic pend_user_v;
		logic [3:0] pend_user;
		logic pend_obf_set;
		logic pend_ibf_clr;
		logic pend_f0_v;
		logic pend_f0;
		logic [7:0] dout;
		logic doe;
		logic [2:0] pins;
		logic [7:0] status_q;
	} shp_st_t;

	shp_st_t st_ff;
	shp_st_t nxt_st;
	logic rst_n;
	logic [1:0] rst_sync_ff;
	shp_attr_t attr;
	logic rd_lead;
	logic rd_trail;
	logic rd_act;
	shp_attr_t rd_attr;
	logic wr_lead;
	logic wr_trail;
	logic wr_act;
	shp_attr_t wr_attr;
	logic transfer_acknowledge_pin_sel;
	logic status_lock;

	// assemble the status byte from its fields
	function automatic logic [7:0] status_of(input shp_st_t s);
		logic [7:0] b;
		b = SHP_STATUS_RST;
		b[SHP_ST_OBF] = s.output_full_flag; // [R15]
		b[SHP_ST_IBF] = s.input_full_flag;
		b[SHP_ST_F0] = s.f0;
		b[SHP_ST_F1] = s.command_data_flag;
		b[SHP_ST_USER_HI:SHP_ST_USER_LO] = s.user_status_bits;
		return b;
	endfunction : status_of

	////////////////////////////////////////////////////////////////////////
	// reset release through two flops; the async edge only asserts
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	////////////////////////////////////////////////////////////////////////
	// access select: with transfers enabled, a low acknowledge is a data-only chip select
	assign transfer_acknowledge_pin_sel = st_ff.dma_en & ~port2_bit7; // [R10]
	// one driver for the whole carrier keeps the select and kind together
	assign attr = '{sel: ~host_in.cs_n | transfer_acknowledge_pin_sel,
		cmd: host_in.command_data_select & ~transfer_acknowledge_pin_sel}; // [R10] [R11]

	shp_strobe u_rd (
		.clk(clk),
		.rst_n(rst_n),
		.strobe_n(host_in.rd_n),
		.attr(attr),
		.lead(rd_lead),
		.trail(rd_trail),
		.active(rd_act),
		.attr_q(rd_attr)
	);

	shp_strobe u_wr (
		.clk(clk),
		.rst_n(rst_n),
		.strobe_n(host_in.wr_n),
		.attr(attr),
		.lead(wr_lead),
		.trail(wr_trail),
		.active(wr_act),
		.attr_q(wr_attr)
	);

	// status read in progress, from its leading edge through its trail
	assign status_lock = (rd_lead & attr.cmd) | (rd_act & rd_attr.cmd); // [R3]

	////////////////////////////////////////////////////////////////////////
	// next state: clears are applied before sets so that a set wins, except the transfer request, whose drops come last and win
	always_comb begin
		nxt_st = st_ff;
		// firmware events, parked while the host samples the status
		if (fw_in.exec_stb && fw_in.opcode == SHP_OPC_STATUS_MOVE) begin
			nxt_st.pend_user_v = 1'b1; // [R1]
			nxt_st.pend_user = fw_in.acc[SHP_ST_USER_HI:SHP_ST_USER_LO];
		end
		if (fw_in.obuf_wr_stb) begin
			nxt_st.obuf = fw_in.obuf_data;
			nxt_st.pend_obf_set = 1'b1; // [R14]
		end
		if (fw_in.ibuf_rd_stb) begin
			nxt_st.pend_ibf_clr = 1'b1; // [R14]
		end
		if (fw_in.f0_wr_stb) begin
			nxt_st.pend_f0_v = 1'b1;
			nxt_st.pend_f0 = fw_in.f0_val;
		end
		if (!status_lock) begin
			// drain parked updates; bits 3..0 untouched by the move
			if (nxt_st.pend_user_v) begin
				nxt_st.user_status_bits = nxt_st.pend_user; // [R1] [R3]
			end
			if (nxt_st.pend_ibf_clr) begin
				nxt_st.input_full_flag = 1'b0;
			end
			if (nxt_st.pend_f0_v) begin
				nxt_st.f0 = nxt_st.pend_f0;
			end
			nxt_st.pend_user_v = 1'b0;
			nxt_st.pend_ibf_clr = 1'b0;
			nxt_st.pend_f0_v = 1'b0;
		end
		// host read: drive on the leading edge, update on the trailing
		if (rd_lead) begin
			nxt_st.doe = 1'b1;
			nxt_st.dout = attr.cmd ? status_of(st_ff) : st_ff.obuf; // [R12]
		end
		if (rd_trail) begin
			nxt_st.doe = 1'b0;
			if (!rd_attr.cmd) begin
				nxt_st.output_full_flag = 1'b0; // [R2] [R14]
			end
		end
		if (!status_lock && nxt_st.pend_obf_set) begin
			nxt_st.output_full_flag = 1'b1; // [R14]
			nxt_st.pend_obf_set = 1'b0;
		end
		// host write: keep the last byte seen while the strobe is low
		if (wr_lead || (wr_act && !host_in.wr_n)) begin
			nxt_st.wr_data = host_in.data;
		end
		if (wr_trail) begin
			nxt_st.ibuf = st_ff.wr_data; // [R13]
			nxt_st.input_full_flag = 1'b1; // [R2] [R14]
			nxt_st.command_data_flag = wr_attr.cmd; // [R11]
		end
		// port 2 latch and transfer request
		if (fw_in.p2_wr_stb) begin
			nxt_st.p2_latch = fw_in.p2_hi;
			if (st_ff.dma_en && fw_in.p2_hi[SHP_P2_DRQ]) begin
				nxt_st.transfer_request_pin = 1'b1; // [R8]
			end
		end
		if (transfer_acknowledge_pin_sel && (rd_lead || wr_lead)) begin
			nxt_st.transfer_request_pin = 1'b0; // [R9]
		end
		if (fw_in.exec_stb && fw_in.opcode == SHP_OPC_EN_FLAGS) begin
			nxt_st.flags_en = 1'b1; // [R5]
		end
		if (fw_in.exec_stb && fw_in.opcode == SHP_OPC_EN_DMA) begin
			nxt_st.dma_en = 1'b1; // [R8]
			nxt_st.transfer_request_pin = 1'b0; // [R9]
		end
		// pin values, plain latch bits until enabled
		nxt_st.pins[SHP_P2_OBF] = nxt_st.p2_latch[SHP_P2_OBF] &
			(~nxt_st.flags_en | nxt_st.output_full_flag); // [R4] [R6]
		nxt_st.pins[SHP_P2_IBF] = nxt_st.p2_latch[SHP_P2_IBF] &
			(~nxt_st.flags_en | ~nxt_st.input_full_flag); // [R4] [R7]
		nxt_st.pins[SHP_P2_DRQ] = nxt_st.dma_en ? nxt_st.transfer_request_pin :
			nxt_st.p2_latch[SHP_P2_DRQ]; // [R4] [R8]
		nxt_st.status_q = status_of(nxt_st);
	end

	// state register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.p2_latch <= SHP_P2_RST;
			st_ff.pins <= SHP_P2_RST[2:0];
			st_ff.user_status_bits <= SHP_USER_RST;
			st_ff.dout <= SHP_BYTE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign host_data_out = st_ff.dout;
	assign host_data_oe = st_ff.doe;
	assign port2_pins = st_ff.pins;
	assign fw_status = st_ff.status_q;
	assign fw_ibuf_data = st_ff.ibuf;

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_STATUS_MOVE: assert property (@(posedge clk) disable iff (!rst_n)
		(fw_in.exec_stb && fw_in.opcode == SHP_OPC_STATUS_MOVE && !status_lock)
		|=> fw_status[7:4] == $past(fw_in.acc[7:4])) // [R1]
		else $error("status move did not land in the user bits");
	AST_LOW_NIBBLE_KEPT: assert property (@(posedge clk) disable iff (!rst_n)
		(fw_in.exec_stb && fw_in.opcode == SHP_OPC_STATUS_MOVE && !status_lock
		&& !fw_in.obuf_wr_stb && !fw_in.ibuf_rd_stb && !fw_in.f0_wr_stb
		&& !rd_trail && !wr_trail && !st_ff.pend_obf_set
		&& !st_ff.pend_ibf_clr && !st_ff.pend_f0_v)
		|=> $stable(fw_status[SHP_ST_F1:SHP_ST_OBF])) // [R1]
		else $error("status move disturbed the low nibble");
	AST_IBF_ON_TRAIL: assert property (@(posedge clk) disable iff (!rst_n)
		wr_trail |=> st_ff.input_full_flag) // [R2]
		else $error("input-full not set after write trail");
	AST_LOCK_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_act && rd_attr.cmd && $past(rd_act)) |-> $stable(st_ff.user_status_bits)) // [R3]
		else $error("status changed during a status read");
	AST_OBF_PIN: assert property (@(posedge clk) disable iff (!rst_n)
		st_ff.flags_en |-> st_ff.pins[SHP_P2_OBF] ==
		(st_ff.p2_latch[SHP_P2_OBF] & st_ff.output_full_flag)) // [R6]
		else $error("output-full pin mismatch");
	AST_IBF_PIN: assert property (@(posedge clk) disable iff (!rst_n)
		st_ff.flags_en |-> st_ff.pins[SHP_P2_IBF] ==
		(st_ff.p2_latch[SHP_P2_IBF] & ~st_ff.input_full_flag)) // [R7]
		else $error("input-full pin mismatch");
	AST_PLAIN_PORT: assert property (@(posedge clk) disable iff (!rst_n)
		(!st_ff.flags_en && !st_ff.dma_en) |-> st_ff.pins == st_ff.p2_latch[2:0]) // [R4]
		else $error("port pins not plain before enable");
	AST_DRQ_DROP: assert property (@(posedge clk) disable iff (!rst_n)
		(fw_in.exec_stb && fw_in.opcode == SHP_OPC_EN_DMA) |=>
		!st_ff.pins[SHP_P2_DRQ] ##1
		(!st_ff.pins[SHP_P2_DRQ] || $past(fw_in.p2_wr_stb))) // [R9]
		else $error("request not dropped by transfer enable");
	AST_READ_SOURCE: assert property (@(posedge clk) disable iff (!rst_n)
		(rd_lead && !attr.cmd) |=> host_data_oe && host_data_out == $past(st_ff.obuf)) // [R12]
		else $error("data read did not return the output buffer");
	AST_WRITE_CMD: assert property (@(posedge clk) disable iff (!rst_n)
		wr_trail |=> fw_status[SHP_ST_F1] == $past(wr_attr.cmd)) // [R11]
		else $error("command flag does not follow the select");

	COV_STATUS_READ: cover property (@(posedge clk) disable iff (!rst_n)
		rd_lead && attr.cmd ##[1:20] rd_trail);
	COV_DATA_WRITE: cover property (@(posedge clk) disable iff (!rst_n)
		wr_trail && !wr_attr.cmd);
	COV_DMA_ACK: cover property (@(posedge clk) disable iff (!rst_n)
		st_ff.transfer_request_pin && transfer_acknowledge_pin_sel && rd_lead);
endmodule : shp_host_port

// file: sim/shp_host_model.sv
// partner model: master cpu and transfer controller on the host bus.
// assumes the port samples its host pins on the rising clock edge.
`timescale 1ns/1ns
module shp_host_model (
	input wire logic clk,
	output shp_pkg::shp_host_in_t host_in,
	output logic port2_bit7,
	input wire logic [7:0] host_data_out
);
	import shp_pkg::*;
	logic [7:0] last_q;
	////////////////////////////////////////////////////////////////////
	// idle bus: nothing selected, strobes high, no acknowledge
	initial begin
		host_in = '1;
		port2_bit7 = 1'b1;
		last_q = 8'hFF;
	end
	// open one strobe; acknowledge stands in for chip select
	task automatic xfer_begin(input logic wr, input logic sel,
		input logic ack, input logic [7:0] wd, output logic [7:0] rd);
		@(posedge clk);
		host_in.cs_n <= ack;
		port2_bit7 <= ~ack;
		host_in.command_data_select <= sel;
		host_in.data <= wd;
		last_q = wd;
		if (wr) begin
			host_in.wr_n <= 1'b0;
		end else begin
			host_in.rd_n <= 1'b0;
		end
		repeat (3) @(posedge clk);
		rd = host_data_out;
	endtask : xfer_begin
	// trailing edge first, select and bus released a cycle later
	task automatic xfer_end();
		@(posedge clk);
		host_in.rd_n <= 1'b1;
		host_in.wr_n <= 1'b1;
		@(posedge clk);
		host_in.cs_n <= 1'b1;
		port2_bit7 <= 1'b1;
		host_in.data <= ~last_q; // a released bus keeps no stale byte
		repeat (2) @(posedge clk);
	endtask : xfer_end
endmodule : shp_host_model

// file: sim/slave_host_port_flags_dma_tb.sv
// self-checking bench for the slave host port.
// assumes the host model drives every host pin of the port.
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
	mismatches++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module slave_host_port_flags_dma_tb;
	import shp_pkg::*;
	typedef struct packed {logic sel; logic [7:0] wd; logic [7:0] st;} shp_row_t;
	logic clk, rstn, port2_bit7, host_data_oe;
	shp_host_in_t host_in;
	shp_fw_in_t fw_in, fw_n;
	logic [7:0] host_data_out, fw_status, fw_ibuf_data, rd;
	logic [2:0] port2_pins;
	int mismatches, tests_run;
	shp_row_t rows [4] = '{'{1'b0, 8'hA5, 8'h02}, '{1'b1, 8'h3C, 8'h0A},
		'{1'b1, 8'hFF, 8'h0A}, '{1'b0, 8'h00, 8'h02}};
	////////////////////////////////////////////////////////////////////
	shp_host_port dut_u (.clk(clk), .rstn(rstn), .host_in(host_in),
		.fw_in(fw_in), .port2_bit7(port2_bit7), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .port2_pins(port2_pins),
		.fw_status(fw_status), .fw_ibuf_data(fw_ibuf_data));
	shp_host_model model_u (.clk(clk), .host_in(host_in),
		.port2_bit7(port2_bit7), .host_data_out(host_data_out));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// one firmware pulse, then wait until its answer has landed
	task automatic fw_go();
		@(posedge clk);
		fw_in <= fw_n;
		@(posedge clk);
		fw_in <= '0;
		repeat (2) @(posedge clk);
		fw_n = '0;
	endtask : fw_go
	task automatic fw_p2(input logic [3:0] v);
		fw_n.p2_wr_stb = 1'b1;
		fw_n.p2_hi = v;
		fw_go();
	endtask : fw_p2
	task automatic fw_exec(input logic [7:0] op, input logic [7:0] a);
		fw_n.exec_stb = 1'b1;
		fw_n.opcode = op;
		fw_n.acc = a;
		fw_go();
	endtask : fw_exec
	task automatic host(input logic wr, input logic sel, input logic ack,
		input logic [7:0] wd);
		model_u.xfer_begin(wr, sel, ack, wd, rd);
		model_u.xfer_end();
	endtask : host
	task automatic results();
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results
	// watchdog: the whole sequence needs well under 1000 cycles
	initial begin
		#100000;
		mismatches++;
		results();
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		fw_in = '0;
		fw_n = '0;
		mismatches = 0;
		tests_run = 0;
		repeat (16) @(posedge clk);
		`CHK(port2_pins, 3'b111)
		`CHK({host_data_oe, fw_status}, 9'h000)
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		// host writes: flags move only after the trailing edge
		foreach (rows[i]) begin
			model_u.xfer_begin(1'b1, rows[i].sel, 1'b0, rows[i].wd, rd);
			`CHK(fw_status[1], 1'b0)
			model_u.xfer_end();
			`CHK(fw_status, rows[i].st)
			`CHK(fw_ibuf_data, rows[i].wd)
			fw_n.ibuf_rd_stb = 1'b1;
			fw_go();
			`CHK(fw_status, rows[i].st & 8'hFD)
		end
		fw_exec(SHP_OPC_STATUS_MOVE, 8'h5F);
		`CHK(fw_status, 8'h50)
		host(1'b0, 1'b1, 1'b0, 8'h00);
		`CHK(rd, 8'h50)
		fw_n.obuf_wr_stb = 1'b1;
		fw_n.obuf_data = 8'hC3;
		fw_go();
		`CHK(fw_status, 8'h51)
		host(1'b0, 1'b0, 1'b0, 8'h00);
		`CHK(rd, 8'hC3)
		`CHK(fw_status, 8'h50)
		// status move during a status read waits for its end
		model_u.xfer_begin(1'b0, 1'b1, 1'b0, 8'h00, rd);
		fw_exec(SHP_OPC_STATUS_MOVE, 8'hA0);
		`CHK(fw_status, 8'h50)
		`CHK({host_data_oe, host_data_out}, 9'h150)
		model_u.xfer_end();
		`CHK(fw_status, 8'hA0)
		fw_p2(4'h0);
		`CHK(port2_pins, 3'b000)
		// flag pins
		fw_exec(SHP_OPC_EN_FLAGS, 8'h00);
		fw_p2(4'hB);
		`CHK(port2_pins, 3'b010)
		fw_n.obuf_wr_stb = 1'b1;
		fw_n.obuf_data = 8'h77;
		fw_go();
		`CHK(port2_pins[0], 1'b1)
		host(1'b1, 1'b0, 1'b0, 8'h11);
		`CHK(port2_pins[1], 1'b0)
		fw_p2(4'h8);
		`CHK(port2_pins[1:0], 2'b00)
		fw_n.ibuf_rd_stb = 1'b1;
		fw_go();
		`CHK(fw_status, 8'hA1)
		fw_n.f0_wr_stb = 1'b1;
		fw_n.f0_val = 1'b1;
		fw_go();
		`CHK(fw_status, 8'hA5)
		// acknowledge before transfer enable selects nothing
		model_u.xfer_begin(1'b0, 1'b1, 1'b1, 8'h00, rd);
		`CHK(host_data_oe, 1'b0)
		model_u.xfer_end();
		`CHK(fw_status[0], 1'b1)
		// transfer handshake: ack read, ack write, re-enable
		fw_exec(SHP_OPC_EN_DMA, 8'h00);
		fw_p2(4'hC);
		`CHK(port2_pins[2], 1'b1)
		model_u.xfer_begin(1'b0, 1'b1, 1'b1, 8'h00, rd);
		`CHK(fw_status[0], 1'b1)
		`CHK(rd, 8'h77)
		model_u.xfer_end();
		`CHK(port2_pins[2], 1'b0)
		`CHK(fw_status[0], 1'b0)
		fw_p2(4'hC);
		`CHK(port2_pins[2], 1'b1)
		host(1'b1, 1'b1, 1'b1, 8'h42);
		`CHK(port2_pins[2], 1'b0)
		`CHK(fw_ibuf_data, 8'h42)
		fw_p2(4'hC);
		`CHK(port2_pins[2], 1'b1)
		fw_exec(SHP_OPC_EN_DMA, 8'h00);
		`CHK(port2_pins[2], 1'b0)
		results();
	end
endmodule : slave_host_port_flags_dma_tb
